// *** pkg/bbcce_params.svh ***
// constants for the bit, branch, call and clear execution slice
`ifndef BBCCE_PARAMS_SVH
`define BBCCE_PARAMS_SVH

// ----------------------------------------------------------------
// opcode fields of the first instruction word and the second call word
// ----------------------------------------------------------------
`define BBCCE_TOGGLE_HI 4'h7
`define BBCCE_BR_OVF_HI 8'hE4
`define BBCCE_BR_ZERO_HI 8'hE0
`define BBCCE_CALL_HI 7'h76
`define BBCCE_CALL2_HI 4'hF
`define BBCCE_CLEAR_HI 7'h35
`define BBCCE_ACC_BIT 8
`define BBCCE_SHADOW_BIT 8

// ----------------------------------------------------------------
// data address map
// ----------------------------------------------------------------
`define BBCCE_IDX_LIMIT 8'h5F
`define BBCCE_ACC_LOW_LIMIT 8'h5F
`define BBCCE_ACC_HIGH_PAGE 4'hF

// ----------------------------------------------------------------
// status flag positions and widths
// ----------------------------------------------------------------
`define BBCCE_FLAG_C 0
`define BBCCE_FLAG_DC 1
`define BBCCE_FLAG_Z 2
`define BBCCE_FLAG_OV 3
`define BBCCE_FLAG_N 4
`define BBCCE_FLAGS_W 5
`define BBCCE_PC_W 21
`define BBCCE_DADDR_W 12

// ----------------------------------------------------------------
// reset values, step sizes and depths
// ----------------------------------------------------------------
`define BBCCE_PC_RESET 21'h000000
`define BBCCE_PC_STEP 21'h000002
`define BBCCE_STACK_DEPTH 31
`define BBCCE_STACK_PTR_W 5
`define BBCCE_PHASES 4

`endif

// *** pkg/bbcce_pkg.sv ***
// types of the bit, branch, call and clear execution slice
package bbcce_pkg;

	typedef enum logic [2:0]
	{
		BBCCE_OP_NONE,
		BBCCE_OP_TOGGLE,
		BBCCE_OP_BR_OVF,
		BBCCE_OP_BR_ZERO,
		BBCCE_OP_CALL,
		BBCCE_OP_CLEAR
	} bbcce_op_t;

	typedef enum logic
	{
		BBCCE_ST_EXEC,
		BBCCE_ST_NOP
	} bbcce_state_t;

	typedef enum logic [1:0]
	{
		BBCCE_Q1,
		BBCCE_Q2,
		BBCCE_Q3,
		BBCCE_Q4
	} bbcce_phase_t;

endpackage

// *** sim/bbcce_core_asserts.sv ***
// concurrent checks on the ports of the execution slice
`timescale 1ns/1ns
`include "bbcce_params.svh"

module bbcce_core_asserts
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [`BBCCE_PC_W-1:0] prog_addr,
	input wire logic dmem_rd_en,
	input wire logic dmem_wr_en,
	input wire logic [7:0] dmem_wdata,
	input wire logic flag_z_set,
	input wire logic [`BBCCE_PC_W-1:0] stack_top,
	input wire logic [`BBCCE_STACK_PTR_W-1:0] stack_ptr,
	input wire logic [1:0] phase,
	input wire logic nop_cycle
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// ----------------------------------------------------------------
	// sequences and properties
	// ----------------------------------------------------------------
	sequence s_rmw;
		dmem_rd_en ##2 dmem_wr_en;
	endsequence
	sequence s_nop4;
		nop_cycle[*4] ##1 !nop_cycle;
	endsequence
	property p_rmw;
		dmem_rd_en |-> s_rmw;
	endproperty
	property p_rd_q2;
		dmem_rd_en |-> phase == 2'h1 && !dmem_wr_en;
	endproperty
	property p_wr_q4;
		dmem_wr_en |-> phase == 2'h3 && !nop_cycle;
	endproperty
	property p_zero;
		flag_z_set |-> dmem_wr_en && dmem_wdata == 8'h00;
	endproperty
	property p_nop;
		$rose(nop_cycle) |-> phase == 2'h0 ##0 s_nop4;
	endproperty
	property p_quiet;
		nop_cycle |-> !dmem_rd_en && !dmem_wr_en && !flag_z_set;
	endproperty
	// the fetch edge always steps by one word, branches land later
	property p_step;
		phase == 2'h0 && !nop_cycle |=>
			prog_addr == $past(prog_addr) + `BBCCE_PC_STEP;
	endproperty
	property p_push;
		stack_top != $past(stack_top) |->
			phase == 2'h3 && stack_ptr == $past(stack_ptr) + 5'h01;
	endproperty

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_rmw: assert property (p_rmw)
		else $error("write did not follow read by two cycles");
	a_rd_q2: assert property (p_rd_q2)
		else $error("read strobe outside second phase");
	a_wr_q4: assert property (p_wr_q4)
		else $error("write strobe outside last phase");
	a_zero: assert property (p_zero)
		else $error("zero flag pulse without zero write");
	a_nop: assert property (p_nop)
		else $error("no-operation cycle not four phases long");
	a_quiet: assert property (p_quiet)
		else $error("memory strobe during no-operation cycle");
	a_step: assert property (p_step)
		else $error("fetch did not advance by two");
	a_push: assert property (p_push)
		else $error("stack top changed without push");
endmodule

bind bbcce_core bbcce_core_asserts bbcce_core_asserts_inst
(
	.core_clk(core_clk),
	.rst(rst),
	.prog_addr(prog_addr),
	.dmem_rd_en(dmem_rd_en),
	.dmem_wr_en(dmem_wr_en),
	.dmem_wdata(dmem_wdata),
	.flag_z_set(flag_z_set),
	.stack_top(stack_top),
	.stack_ptr(stack_ptr),
	.phase(phase),
	.nop_cycle(nop_cycle)
);

// *** sim/tb_top.sv ***
// self-checking bench for the execution slice
`timescale 1ns/1ns
`include "bbcce_params.svh"

module tb_top;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic ext_set_en = 1'b0;
	logic [15:0] prog_word = 16'h0000;
	logic [7:0] working_reg = 8'h00;
	logic [4:0] status_flags = 5'h00;
	logic [3:0] bank_select_reg = 4'h0;
	logic [11:0] index_base = 12'h000;
	logic [7:0] dmem_rdata = 8'h75;
	logic [20:0] prog_addr, stack_top;
	logic [11:0] dmem_addr, wr_addr;
	logic dmem_rd_en, dmem_wr_en, flag_z_set, stack_full, nop_cycle;
	logic [7:0] dmem_wdata, working_shadow, wr_data;
	logic [4:0] flags_shadow, stack_ptr;
	logic [3:0] bank_select_shadow;
	logic [1:0] phase;
	int wr_cnt, z_cnt, bad_count, checks;
	logic [20:0] a;
	int cyc;

	always #50 core_clk = ~core_clk;

	bbcce_core bbcce_core_inst
	(
		.core_clk(core_clk), .rst(rst), .ext_set_en(ext_set_en),
		.prog_word(prog_word), .prog_addr(prog_addr),
		.working_reg(working_reg), .status_flags(status_flags),
		.bank_select_reg(bank_select_reg), .index_base(index_base),
		.dmem_addr(dmem_addr), .dmem_rd_en(dmem_rd_en),
		.dmem_rdata(dmem_rdata), .dmem_wr_en(dmem_wr_en),
		.dmem_wdata(dmem_wdata), .flag_z_set(flag_z_set),
		.working_shadow(working_shadow), .flags_shadow(flags_shadow),
		.bank_select_shadow(bank_select_shadow), .stack_top(stack_top),
		.stack_ptr(stack_ptr), .stack_full(stack_full),
		.phase(phase), .nop_cycle(nop_cycle)
	);

	// ----------------------------------------------------------------
	// write monitor and shared tasks
	// ----------------------------------------------------------------
	always @(posedge core_clk)
	begin
		if (dmem_wr_en === 1'b1)
		begin
			wr_cnt <= wr_cnt + 1;
			wr_addr <= dmem_addr;
			wr_data <= dmem_wdata;
		end
		if (flag_z_set === 1'b1)
			z_cnt <= z_cnt + 1;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// called at a falling edge in the fetch phase; returns there too
	task automatic run(input logic [15:0] w1, input logic [15:0] w2);
		wr_cnt = 0;
		z_cnt = 0;
		a = prog_addr;
		prog_word = w1;
		cyc = 0;
		do
		begin
			@(negedge core_clk);
			cyc++;
			if (phase === 2'h2)
				prog_word = w2;
		end
		while (!(phase === 2'h0 && nop_cycle === 1'b0) && cyc < 20);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_toggle;
		bank_select_reg = 4'h5;
		for (int b = 0; b < 8; b++)
		begin
			run(16'h713C | 16'(b << 9), 16'h0000);
			check(cyc, 4);
			check(prog_addr, a + 21'h000002);
			check(wr_cnt, 1);
			check(wr_addr, 12'h53C);
			check(wr_data, 8'h75 ^ (8'h01 << b));
			check(z_cnt, 0);
		end
	endtask

	task automatic t_clear;
		logic [11:0] ex [5] = '{12'h020, 12'h320, 12'h35F, 12'hF60, 12'h520};
		logic [15:0] w [5] = '{16'h6A20, 16'h6A20, 16'h6A5F, 16'h6A60,
			16'h6B20};
		index_base = 12'h300;
		for (int i = 0; i < 5; i++)
		begin
			ext_set_en = (i == 1 || i == 2 || i == 3);
			run(w[i], 16'h0000);
			check(wr_addr, ex[i]);
			check(wr_data, 8'h00);
			check(z_cnt, 1);
			check(cyc, 4);
		end
		ext_set_en = 1'b0;
	endtask

	task automatic t_branch;
		logic [15:0] w [5] = '{16'hE0FD, 16'hE0FD, 16'hE47F, 16'hE47F,
			16'hE480};
		logic [4:0] fl [5] = '{5'h04, 5'h08, 5'h08, 5'h04, 5'h1F};
		logic tk [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
		logic [20:0] exp;
		for (int i = 0; i < 5; i++)
		begin
			status_flags = fl[i];
			run(w[i], 16'h0000);
			exp = a + 21'h000002;
			if (tk[i])
				exp = exp + {{12{w[i][7]}}, w[i][7:0], 1'b0};
			check(prog_addr, exp);
			check(cyc, tk[i] ? 8 : 4);
			check(wr_cnt, 0);
		end
	endtask

	task automatic t_call;
		logic [4:0] sp0;
		working_reg = 8'h3C;
		status_flags = 5'h15;
		bank_select_reg = 4'h9;
		for (int s = 0; s < 2; s++)
		begin
			sp0 = stack_ptr;
			run(16'hECDE | 16'(s << 8), 16'hFABC);
			check(cyc, 8);
			check(stack_top, a + 21'h000004);
			check(stack_ptr, sp0 + 5'h01);
			check(prog_addr, 21'h1579BC);
			check(wr_cnt, 0);
			check(working_shadow, s ? 8'h3C : 8'h00);
			check(flags_shadow, s ? 5'h15 : 5'h00);
			check(bank_select_shadow, s ? 4'h9 : 4'h0);
		end
	endtask

	// calls without save until the stack is full, then one push too many
	task automatic t_full;
		logic [20:0] top0;
		logic [4:0] ep;
		logic full0;
		ep = stack_ptr;
		working_reg = 8'hC3;
		status_flags = 5'h0A;
		for (int i = 0; i < 30; i++)
		begin
			top0 = stack_top;
			full0 = (ep == `BBCCE_STACK_DEPTH);
			run(16'hEC00 | 16'(i), 16'hF000);
			if (!full0)
				ep++;
			check(cyc, 8);
			check(prog_addr, 21'(i + i));
			check(stack_ptr, ep);
			check(stack_full, ep == `BBCCE_STACK_DEPTH);
			check(stack_top, full0 ? top0 : a + 21'h000004);
		end
		check(working_shadow, 8'h3C);
		check(flags_shadow, 5'h15);
		check(bank_select_shadow, 4'h9);
	endtask

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		repeat (20) @(negedge core_clk);
		rst = 1'b0;
		t_toggle();
		t_clear();
		t_branch();
		t_call();
		t_full();
		end_sim();
	end

	// the tests need a few hundred cycles; ten times that is a hang
	initial
	begin
		#400000;
		bad_count++;
		end_sim();
	end
endmodule

// *** verilog/bbcce_core.sv ***
// execution slice for bit toggle, two branches, call and clear
`timescale 1ns/1ns
`include "bbcce_params.svh"

// Function
// - toggle decodes from upper byte 0111 bbba plus 8-bit file address.
// - toggle inverts only the chosen bit, no flags, one word, one cycle.
// - access flag 0 picks access bank, 1 uses bank select register.
// - flag 0 with extended set: addresses up to 95 are indexed offsets.
// - overflow branch is 1110 0100 plus offset, taken when overflow set.
// - zero branch is 1110 0000 plus offset, taken when zero flag set.
// - taken branch target is instruction address plus 2 plus twice offset.
// - branch takes one cycle untaken, adds a no-operation cycle if taken.
// - taken branch reads offset, processes it, writes PC in last phase.
// - call is 1110 110s with low target byte, then 1111 with high bits.
// - call pushes its address plus 4 as the new stack top, unless the stack is full.
// - call with s set copies W, status and bank select into shadows.
// - after push, the 20-bit target loads PC bits 20 to 1; no flags.
// - call is two words, two cycles; second cycle is a no-operation.
// - clear is 0110 101a with file address, writes zero, sets zero flag.
// - file operations run decode, read, process, write in four phases.
module bbcce_core
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ext_set_en,
	input wire logic [15:0] prog_word,
	output logic [`BBCCE_PC_W-1:0] prog_addr,
	input wire logic [7:0] working_reg,
	input wire logic [`BBCCE_FLAGS_W-1:0] status_flags,
	input wire logic [3:0] bank_select_reg,
	input wire logic [`BBCCE_DADDR_W-1:0] index_base,
	output logic [`BBCCE_DADDR_W-1:0] dmem_addr,
	output logic dmem_rd_en,
	input wire logic [7:0] dmem_rdata,
	output logic dmem_wr_en,
	output logic [7:0] dmem_wdata,
	output logic flag_z_set,
	output logic [7:0] working_shadow,
	output logic [`BBCCE_FLAGS_W-1:0] flags_shadow,
	output logic [3:0] bank_select_shadow,
	output logic [`BBCCE_PC_W-1:0] stack_top,
	output logic [`BBCCE_STACK_PTR_W-1:0] stack_ptr,
	output logic stack_full,
	output logic [1:0] phase,
	output logic nop_cycle
);

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic bbcce_pkg::bbcce_op_t decode_op(
		input logic [15:0] w);
		bbcce_pkg::bbcce_op_t op;
		op = bbcce_pkg::BBCCE_OP_NONE;
		if (w[15:12] == `BBCCE_TOGGLE_HI)
			op = bbcce_pkg::BBCCE_OP_TOGGLE;
		else if (w[15:8] == `BBCCE_BR_OVF_HI)
			op = bbcce_pkg::BBCCE_OP_BR_OVF;
		else if (w[15:8] == `BBCCE_BR_ZERO_HI)
			op = bbcce_pkg::BBCCE_OP_BR_ZERO;
		else if (w[15:9] == `BBCCE_CALL_HI)
			op = bbcce_pkg::BBCCE_OP_CALL;
		else if (w[15:9] == `BBCCE_CLEAR_HI)
			op = bbcce_pkg::BBCCE_OP_CLEAR;
		return op;
	endfunction

	// file address to data address, shared by both file operations
	function automatic logic [`BBCCE_DADDR_W-1:0] file_addr(
		input logic [7:0] f,
		input logic acc,
		input logic ext,
		input logic [3:0] bank,
		input logic [`BBCCE_DADDR_W-1:0] idx_base);
		logic [`BBCCE_DADDR_W-1:0] ea;
		ea = {bank, f};
		if (!acc)
		begin
			if (ext && (f <= `BBCCE_IDX_LIMIT))
				ea = idx_base + {4'h0, f};
			else if (f <= `BBCCE_ACC_LOW_LIMIT)
				ea = {4'h0, f};
			else
				ea = {`BBCCE_ACC_HIGH_PAGE, f};
		end
		return ea;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	bbcce_pkg::bbcce_state_t st_r;
	bbcce_pkg::bbcce_state_t st_nxt;
	bbcce_pkg::bbcce_phase_t ph_r;
	bbcce_pkg::bbcce_phase_t ph_nxt;
	bbcce_pkg::bbcce_op_t op_r;
	bbcce_pkg::bbcce_op_t op_dec;
	logic [`BBCCE_PC_W-1:0] pc_r;
	logic [`BBCCE_PC_W-1:0] pc_nxt;
	logic [15:0] ir_r;
	logic [11:0] khi_r;
	logic [`BBCCE_DADDR_W-1:0] ea_r;
	logic [`BBCCE_DADDR_W-1:0] ea_nxt;
	logic [7:0] data_r;
	logic [7:0] res_r;
	logic [7:0] res_nxt;
	logic [`BBCCE_PC_W-1:0] tgt_r;
	logic [`BBCCE_PC_W-1:0] tgt_nxt;
	logic take_r;
	logic take_nxt;
	logic [7:0] wsh_r;
	logic [`BBCCE_FLAGS_W-1:0] fsh_r;
	logic [3:0] bsh_r;

	// ----------------------------------------------------------------
	// phase and cycle qualifiers
	// ----------------------------------------------------------------
	logic in_exec;
	logic end_q1;
	logic end_q2;
	logic end_q3;
	logic end_q4;
	logic is_file_op;
	logic is_branch;
	logic is_call;
	logic branch_cond;
	logic call_push;
	logic call_load;
	logic shadow_load;
	logic [7:0] bit_mask;

	assign in_exec = (st_r == bbcce_pkg::BBCCE_ST_EXEC);
	assign end_q1 = in_exec & (ph_r == bbcce_pkg::BBCCE_Q1);
	assign end_q2 = in_exec & (ph_r == bbcce_pkg::BBCCE_Q2);
	assign end_q3 = in_exec & (ph_r == bbcce_pkg::BBCCE_Q3);
	assign end_q4 = in_exec & (ph_r == bbcce_pkg::BBCCE_Q4);

	assign op_dec = decode_op(prog_word);
	assign is_file_op = (op_r == bbcce_pkg::BBCCE_OP_TOGGLE) |
		(op_r == bbcce_pkg::BBCCE_OP_CLEAR);
	assign is_branch = (op_r == bbcce_pkg::BBCCE_OP_BR_OVF) |
		(op_r == bbcce_pkg::BBCCE_OP_BR_ZERO);
	assign is_call = (op_r == bbcce_pkg::BBCCE_OP_CALL);

	// ----------------------------------------------------------------
	// file operand path: address at decode, read, process, write
	// ----------------------------------------------------------------
	assign ea_nxt = file_addr(prog_word[7:0],
		prog_word[`BBCCE_ACC_BIT], ext_set_en, bank_select_reg,
		index_base);

	assign bit_mask = 8'h01 << ir_r[11:9];
	// toggle flips one bit; clear forces the whole byte to zero
	assign res_nxt = (op_r == bbcce_pkg::BBCCE_OP_TOGGLE) ?
		(data_r ^ bit_mask) : 8'h00;

	assign dmem_addr = ea_r;
	assign dmem_rd_en = end_q2 & is_file_op;
	assign dmem_wr_en = end_q4 & is_file_op;
	assign dmem_wdata = res_r;
	// only clear touches a flag; toggle, branches and call leave them
	assign flag_z_set = end_q4 &
		(op_r == bbcce_pkg::BBCCE_OP_CLEAR);

	// ----------------------------------------------------------------
	// branch path
	// ----------------------------------------------------------------
	assign branch_cond = (op_r == bbcce_pkg::BBCCE_OP_BR_OVF) ?
		status_flags[`BBCCE_FLAG_OV] :
		status_flags[`BBCCE_FLAG_Z];

	// pc already holds address plus 2, so only twice the offset is added
	assign tgt_nxt = pc_r + {{12{ir_r[7]}}, ir_r[7:0], 1'b0};
	assign take_nxt = is_branch & branch_cond;

	// ----------------------------------------------------------------
	// call path
	// ----------------------------------------------------------------
	// second word is read at pc (address plus 2) during the third phase
	assign call_push = end_q3 & is_call;
	assign call_load = end_q4 & is_call;
	assign shadow_load = call_load & ir_r[`BBCCE_SHADOW_BIT];

	// ----------------------------------------------------------------
	// program counter
	// ----------------------------------------------------------------
	assign pc_nxt =
		end_q1 ? (pc_r + `BBCCE_PC_STEP) :
		call_push ? (pc_r + `BBCCE_PC_STEP) :
		call_load ? {khi_r, ir_r[7:0], 1'b0} :
		(end_q4 & take_r) ? tgt_r :
		pc_r;

	// ----------------------------------------------------------------
	// phase and cycle sequencing
	// ----------------------------------------------------------------
	assign ph_nxt = bbcce_pkg::bbcce_phase_t'(ph_r + 2'h1);

	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			bbcce_pkg::BBCCE_ST_EXEC:
			begin
				// taken branch and call both spend a dead cycle
				if (end_q4 & (take_r | is_call))
					st_nxt = bbcce_pkg::BBCCE_ST_NOP;
			end
			bbcce_pkg::BBCCE_ST_NOP:
			begin
				if (ph_r == bbcce_pkg::BBCCE_Q4)
					st_nxt = bbcce_pkg::BBCCE_ST_EXEC;
			end
			default:
				st_nxt = bbcce_pkg::BBCCE_ST_EXEC;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			st_r <= bbcce_pkg::BBCCE_ST_EXEC;
			ph_r <= bbcce_pkg::BBCCE_Q1;
			pc_r <= `BBCCE_PC_RESET;
		end
		else
		begin
			st_r <= st_nxt;
			ph_r <= ph_nxt;
			pc_r <= pc_nxt;
		end
	end

	// ----------------------------------------------------------------
	// decode latch, first phase
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ir_r <= 16'h0000;
			op_r <= bbcce_pkg::BBCCE_OP_NONE;
			ea_r <= 12'h000;
		end
		else if (end_q1)
		begin
			ir_r <= prog_word;
			op_r <= op_dec;
			ea_r <= ea_nxt;
		end
	end

	// ----------------------------------------------------------------
	// operand read, process and branch target
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			data_r <= 8'h00;
		else if (dmem_rd_en)
			data_r <= dmem_rdata;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			res_r <= 8'h00;
			tgt_r <= `BBCCE_PC_RESET;
			take_r <= 1'b0;
		end
		else if (end_q3)
		begin
			res_r <= res_nxt;
			tgt_r <= tgt_nxt;
			take_r <= take_nxt;
		end
		else if (end_q4)
			take_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// high target bits from the second call word
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			khi_r <= 12'h000;
		else if (call_push)
			khi_r <= prog_word[11:0];
	end

	// ----------------------------------------------------------------
	// shadow copies on a call with the save bit set
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			wsh_r <= 8'h00;
			fsh_r <= 5'h00;
			bsh_r <= 4'h0;
		end
		else if (shadow_load)
		begin
			wsh_r <= working_reg;
			fsh_r <= status_flags;
			bsh_r <= bank_select_reg;
		end
	end

	// ----------------------------------------------------------------
	// return stack
	// ----------------------------------------------------------------
	// push value is address plus 4: pc plus 2 before the second step
	bbcce_ret_stack u_stack
	(
		.core_clk(core_clk),
		.rst(rst),
		.push(call_push),
		.push_data(pc_r + `BBCCE_PC_STEP),
		.stack_top(stack_top),
		.stack_ptr(stack_ptr),
		.stack_full(stack_full)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prog_addr = pc_r;
	assign working_shadow = wsh_r;
	assign flags_shadow = fsh_r;
	assign bank_select_shadow = bsh_r;
	assign phase = ph_r;
	assign nop_cycle = ~in_exec;

endmodule

// *** verilog/bbcce_ret_stack.sv ***
// hardware return stack written by the call instruction
`timescale 1ns/1ns
`include "bbcce_params.svh"

module bbcce_ret_stack
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic push,
	input wire logic [`BBCCE_PC_W-1:0] push_data,
	output logic [`BBCCE_PC_W-1:0] stack_top,
	output logic [`BBCCE_STACK_PTR_W-1:0] stack_ptr,
	output logic stack_full
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [`BBCCE_PC_W-1:0] mem [1:`BBCCE_STACK_DEPTH];
	logic [`BBCCE_PC_W-1:0] top_r;
	logic [`BBCCE_STACK_PTR_W-1:0] ptr_r;
	logic [`BBCCE_STACK_PTR_W-1:0] ptr_nxt;
	logic full_w;
	logic do_push;

	// a push onto a full stack is dropped so the oldest returns survive
	assign full_w = (ptr_r == `BBCCE_STACK_PTR_W'(`BBCCE_STACK_DEPTH));
	assign do_push = push & ~full_w;
	assign ptr_nxt = ptr_r + `BBCCE_STACK_PTR_W'(1);

	always_ff @(posedge core_clk)
	begin
		if (do_push)
			mem[ptr_nxt] <= push_data;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ptr_r <= 5'h00;
			top_r <= `BBCCE_PC_RESET;
		end
		else if (do_push)
		begin
			ptr_r <= ptr_nxt;
			top_r <= push_data;
		end
	end

	assign stack_top = top_r;
	assign stack_ptr = ptr_r;
	assign stack_full = full_w;

endmodule
